// file: rtl/tci_interp.sv
/*
  Command interpreter of a bus-addressed transmitter: parses request frames
  (float read, integer read, zero-point commands, configuration read),
  checks address and CRC16, and sends data or exception frames.
  Assumes byte framing is done outside on the same clock, measured values
  arrive prescaled, and a calibration engine applies zero-point writes.
*/
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "tci_map.svh"
module tci_interp
  import tci_pkg::*;
#(
  parameter logic [1:0] VARIANT = `TCI_VAR_DUAL
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Received bytes
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_last,
  // Transmitted bytes
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  input wire logic i_tx_ready,
  // Measurement state
  input wire logic [11:0][31:0] i_chan_float,
  input wire logic [5:0][31:0] i_chan_int,
  input wire logic i_powerup_flag,
  input wire logic i_analog_calc_error_flag,
  input wire logic [5:0] i_chan_err,
  input wire logic [8:0][39:0] i_config_param_byte,
  // Zero-point write to calibration engine
  output logic o_zp_wr,
  output logic [3:0] o_zp_chan,
  output logic [31:0] o_zp_ref,
  output logic [31:0] o_zp_target,
  output logic o_zp_reset,
  input wire logic i_zp_done,
  input wire logic i_zp_fail
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // CRC16 over the first n bytes of the buffer
  function automatic logic [15:0] crc_calc(input tci_buf_t b, input logic [3:0] n);
    logic [15:0] c;
    c = `TCI_CRC_INIT;
    for (int i = 0; i < `TCI_BUF_DEPTH; i++) begin
      if (4'(i) < n) begin
        c = c ^ {8'h00, b[i]};
        for (int k = 0; k < 8; k++) begin
          c = c[0] ? ((c >> 1) ^ `TCI_CRC_POLY) : (c >> 1);
        end
      end
    end
    return c;
  endfunction

  // Special float values forced into integer limits
  function automatic logic [31:0] int_value(input logic [31:0] f, input logic [31:0] v);
    logic special;
    special = (f[30:23] == `TCI_FP_EXP_ONES);
    if (special && f[31] && (f[22:0] == 23'h000000)) begin
      return `TCI_INT_NEG_LIMIT;
    end else if (special) begin
      return `TCI_INT_POS_LIMIT;
    end
    return v;
  endfunction

  tci_state_s s_r, s_nxt;
  logic [15:0] crc;
  logic [7:0] fn;
  logic [7:0] arg;
  logic [7:0] stat_byte;
  logic [31:0] fval;
  logic [31:0] ival;
  logic [31:0] setpt;
  logic [3:0] zchan;
  logic cmd_ok;
  logic [7:0] max_ch;

  // ----------------------------------------------------------------
  // Decode terms
  // ----------------------------------------------------------------
  // Request fields, status byte and channel selection
  always_comb begin
    // Checksum of the body
    crc = crc_calc(s_r.buf_r, s_r.cnt - 4'h2);

    // Function code and argument
    fn = s_r.buf_r[1];
    arg = s_r.buf_r[2];

    // Live status byte
    stat_byte = {i_powerup_flag, i_analog_calc_error_flag, i_chan_err};

    // Channel values, range checked later
    fval = i_chan_float[arg[3:0]];
    ival = int_value(i_chan_float[arg[3:0]], i_chan_int[arg[2:0]]);

    // Set point, high byte first
    setpt = {s_r.buf_r[3], s_r.buf_r[4], s_r.buf_r[5], s_r.buf_r[6]};

    // Top float channel
    max_ch = (VARIANT == `TCI_VAR_CONDUCT) ? `TCI_MAX_CH_CONDUCT : `TCI_MAX_CH_FLOAT;

    // Command code to channel index
    case (arg[3:1])
      3'h0: zchan = 4'h1;
      3'h1: zchan = 4'h2;
      3'h3: zchan = 4'h0;
      3'h4: zchan = 4'h3;
      3'h5: zchan = 4'h4;
      3'h6: zchan = 4'h5;
      default: zchan = 4'h0;
    endcase

    // Codes that exist on this variant
    cmd_ok = (arg <= `TCI_MAX_ZERO_CMD) && (arg[3:1] != 3'h2);
    // No calculated channel zero
    if (arg[3:1] == 3'h3 && VARIANT == `TCI_VAR_CONDUCT) begin
      cmd_ok = 1'b0;
    end
    // No temperature zeros
    if (arg >= 8'h08 && VARIANT == `TCI_VAR_BASIC) begin
      cmd_ok = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    // Hold state; write strobe is a pulse
    s_nxt = s_r;
    s_nxt.zp_wr = 1'b0;

    // Bus slave: one wait cycle, then the answer
    s_nxt.wait_r = 1'b1;
    if ((i_avs_read || i_avs_write) && s_r.wait_r) begin
      s_nxt.wait_r = 1'b0;
      s_nxt.rdata = 32'h00000000;
      // Unmapped offsets read zero
      if (i_avs_address == `TCI_OFS_CTRL) begin
        s_nxt.rdata[`TCI_CTRL_INIT_BIT] = s_r.dev_init;
        s_nxt.rdata[`TCI_CTRL_ADDR_LSB +: 8] = s_r.node_addr;
      end else if (i_avs_address == `TCI_OFS_STAT) begin
        s_nxt.rdata[`TCI_STAT_EXC_LSB +: 8] = s_r.exc;
        s_nxt.rdata[`TCI_STAT_BUSY_BIT] = (s_r.st != ST_RX);
        s_nxt.rdata[`TCI_STAT_BYTE_LSB +: 8] = stat_byte;
      end
    end

    // Write lands while waitrequest is low
    if (i_avs_write && !s_r.wait_r && i_avs_address == `TCI_OFS_CTRL) begin
      s_nxt.dev_init = i_avs_writedata[`TCI_CTRL_INIT_BIT];
      s_nxt.node_addr = i_avs_writedata[`TCI_CTRL_ADDR_LSB +: 8];
    end

    // Frame engine
    case (s_r.st)
      ST_RX: begin
        if (i_rx_valid) begin
          // Store while room is left
          if (s_r.cnt < 4'(`TCI_BUF_DEPTH)) begin
            s_nxt.buf_r[s_r.cnt] = i_rx_data;
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else begin
            s_nxt.ovf = 1'b1;
          end
          // Last byte closes the frame
          if (i_rx_last) begin
            s_nxt.st = ST_CHECK;
          end
        end
      end

      ST_CHECK: begin
        // Drop frames that are too long, short, corrupt or for another node
        s_nxt.st = ST_EXEC;
        if (s_r.ovf || s_r.cnt < `TCI_LEN_MIN ||
            crc != {s_r.buf_r[s_r.cnt - 4'h2], s_r.buf_r[s_r.cnt - 4'h1]} ||
            (s_r.buf_r[0] != s_r.node_addr && s_r.buf_r[0] != `TCI_TRANSPARENT_ADDR)) begin
          s_nxt.st = ST_RX;
          s_nxt.cnt = 4'h0;
          s_nxt.ovf = 1'b0;
        end
      end

      ST_EXEC: begin
        // Reply built over the request
        s_nxt.st = ST_CRC;
        s_nxt.exc = 8'h00;
        case (fn)
          `TCI_FN_READ_FLOAT: begin
            if (s_r.cnt != `TCI_LEN_SHORT) begin
              s_nxt.exc = `TCI_EXC_LEN;
            end else if (arg > max_ch) begin
              s_nxt.exc = `TCI_EXC_ARG;
            end else begin
              // Value high byte first, then status
              s_nxt.buf_r[2] = fval[31:24];
              s_nxt.buf_r[3] = fval[23:16];
              s_nxt.buf_r[4] = fval[15:8];
              s_nxt.buf_r[5] = fval[7:0];
              s_nxt.buf_r[6] = stat_byte;
              s_nxt.cnt = `TCI_LEN_VALUE;
            end
          end

          `TCI_FN_READ_INT: begin
            if (s_r.cnt != `TCI_LEN_SHORT) begin
              s_nxt.exc = `TCI_EXC_LEN;
            end else if (arg > `TCI_MAX_CH_INT) begin
              s_nxt.exc = `TCI_EXC_ARG;
            end else begin
              // Value high byte first, then status
              s_nxt.buf_r[2] = ival[31:24];
              s_nxt.buf_r[3] = ival[23:16];
              s_nxt.buf_r[4] = ival[15:8];
              s_nxt.buf_r[5] = ival[7:0];
              s_nxt.buf_r[6] = stat_byte;
              s_nxt.cnt = `TCI_LEN_VALUE;
            end
          end

          `TCI_FN_ZERO: begin
            // Length, code, mode, set point
            if (s_r.cnt != `TCI_LEN_SHORT && s_r.cnt != `TCI_LEN_POINT) begin
              s_nxt.exc = `TCI_EXC_LEN;
            end else if (!cmd_ok) begin
              s_nxt.exc = `TCI_EXC_ARG;
            end else if (i_powerup_flag) begin
              s_nxt.exc = `TCI_EXC_MODE;
            end else if (VARIANT == `TCI_VAR_CONDUCT && s_r.cnt == `TCI_LEN_POINT && !arg[0] &&
                         setpt[30:23] == `TCI_FP_EXP_ONES) begin
              s_nxt.exc = `TCI_EXC_MODE;
            end else begin
              // Offset is zp_ref minus zp_target in the calibration engine
              s_nxt.zp_wr = 1'b1;
              s_nxt.zp_chan = zchan;
              s_nxt.zp_ref = i_chan_float[zchan];
              s_nxt.zp_reset = arg[0];
              s_nxt.zp_target = `TCI_FP_ZERO;
              if (!arg[0] && s_r.cnt == `TCI_LEN_POINT) begin
                s_nxt.zp_target = setpt;
              end
              s_nxt.st = ST_WAITZP;
            end
          end

          `TCI_FN_READ_CFG: begin
            if (s_r.cnt != `TCI_LEN_SHORT) begin
              s_nxt.exc = `TCI_EXC_LEN;
            end else if (arg > `TCI_MAX_CFG_INDEX) begin
              s_nxt.exc = `TCI_EXC_ARG;
            end else begin
              // First parameter first
              for (int i = 0; i < 5; i++) begin
                s_nxt.buf_r[2 + i] = i_config_param_byte[arg[3:0]][8*i +: 8];
              end
              s_nxt.cnt = `TCI_LEN_VALUE;
            end
          end

          default: begin
            // Other functions are served elsewhere
            s_nxt.st = ST_RX;
            s_nxt.cnt = 4'h0;
          end
        endcase
        // Uninitialised device refuses every function above
        if (!s_r.dev_init && (fn == `TCI_FN_READ_FLOAT || fn == `TCI_FN_READ_INT ||
                              fn == `TCI_FN_ZERO || fn == `TCI_FN_READ_CFG)) begin
          s_nxt.exc = `TCI_EXC_INIT;
          s_nxt.zp_wr = 1'b0;
          // Zero-point outputs keep the last write
          s_nxt.zp_chan = s_r.zp_chan;
          s_nxt.zp_ref = s_r.zp_ref;
          s_nxt.zp_target = s_r.zp_target;
          s_nxt.zp_reset = s_r.zp_reset;
          s_nxt.st = ST_CRC;
        end
        // Exception frame: flagged function, code
        if (s_nxt.exc != 8'h00) begin
          s_nxt.buf_r[1] = fn | `TCI_EXC_FLAG;
          s_nxt.buf_r[2] = s_nxt.exc;
          s_nxt.cnt = `TCI_LEN_SHORT;
        end
      end

      ST_WAITZP: begin
        // Fail is sampled with done
        if (i_zp_done) begin
          s_nxt.st = ST_CRC;
          s_nxt.buf_r[2] = 8'h00;
          s_nxt.cnt = `TCI_LEN_SHORT;
          if (i_zp_fail && VARIANT == `TCI_VAR_CONDUCT) begin
            s_nxt.exc = `TCI_EXC_SAVE;
            s_nxt.buf_r[1] = fn | `TCI_EXC_FLAG;
            s_nxt.buf_r[2] = `TCI_EXC_SAVE;
          end
        end
      end

      ST_CRC: begin
        // Checksum behind the body
        s_nxt.buf_r[s_r.cnt - 4'h2] = crc[15:8];
        s_nxt.buf_r[s_r.cnt - 4'h1] = crc[7:0];
        s_nxt.st = ST_SEND;
        s_nxt.txi = 4'h0;
        s_nxt.tx_valid = 1'b1;
        s_nxt.tx_data = s_r.buf_r[0];
        s_nxt.tx_last = 1'b0;
      end

      ST_SEND: begin
        // One byte per handshake
        if (i_tx_ready) begin
          // Last byte taken: back to idle
          if (s_r.tx_last) begin
            s_nxt.tx_valid = 1'b0;
            s_nxt.tx_last = 1'b0;
            s_nxt.st = ST_RX;
            s_nxt.cnt = 4'h0;
          end else begin
            s_nxt.txi = s_r.txi + 4'h1;
            s_nxt.tx_data = s_r.buf_r[s_r.txi + 4'h1];
            s_nxt.tx_last = (s_r.txi + 4'h2 == s_r.cnt);
          end
        end
      end

      default: begin
        s_nxt.st = ST_RX;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      // Idle, bus at rest, default node
      s_r <= '0;
      s_r.st <= ST_RX;
      s_r.wait_r <= 1'b1;
      s_r.node_addr <= `TCI_RST_NODE_ADDR;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_avs_readdata = s_r.rdata;
  assign o_avs_waitrequest = s_r.wait_r;
  assign o_tx_valid = s_r.tx_valid;
  assign o_tx_data = s_r.tx_data;
  assign o_tx_last = s_r.tx_last;
  assign o_zp_wr = s_r.zp_wr;
  assign o_zp_chan = s_r.zp_chan;
  assign o_zp_ref = s_r.zp_ref;
  assign o_zp_target = s_r.zp_target;
  assign o_zp_reset = s_r.zp_reset;

endmodule

// file: rtl/tci_map.svh
/*
  Constants of the transmitter command interpreter: bus offsets, reset
  values, function codes, exception codes and frame lengths.
  Assumes inclusion by tci_pkg, the interpreter module and the bench.
*/
// Behaviour
// - Integer read sends four bytes, MSB first
// - Integer values arrive prescaled per channel unit
// - Conductivity channels refused on integer read
// - Overflow, underflow, inactive shown in value
// - Uninitialised device answers exception 32
// - Zero command: power-up exc 1, bad code 2
// - Zero command of wrong length: exception 3
// - Configuration read of wrong length: exception 3
// - Codes 0 and 2 set pressure zeros
// - Codes 1 and 3 reset pressure zeros
// - Codes 6 and 7 for calculated channel
// - Codes 8 to 13 for temperature zeros
// - Plain set makes present value zero
// - Set point form makes value equal point
// - Reset writes 0.0 as zero value
// - Conductivity variant: bad point 1, save fail 4
// - Configuration read returns five parameter bytes
// - Float bytes: byte 0 holds bits 31..24
// - Single precision, fixed special encodings
// - Floats already in engineering unit
// - Status byte: power-up, analog error, channels
`ifndef TCI_MAP_SVH
`define TCI_MAP_SVH
// ----------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------
`define TCI_OFS_CTRL 4'h0
`define TCI_OFS_STAT 4'h4
`define TCI_CTRL_INIT_BIT 0
`define TCI_CTRL_ADDR_LSB 8
`define TCI_STAT_EXC_LSB 0
`define TCI_STAT_BUSY_BIT 8
`define TCI_STAT_BYTE_LSB 16
`define TCI_RST_NODE_ADDR 8'h01
`define TCI_TRANSPARENT_ADDR 8'hfa
// ----------------------------------------------------------------
// Protocol
// ----------------------------------------------------------------
`define TCI_BUF_DEPTH 9
`define TCI_FN_READ_FLOAT 8'h49
`define TCI_FN_READ_INT 8'h4a
`define TCI_FN_ZERO 8'h5f
`define TCI_FN_READ_CFG 8'h64
`define TCI_EXC_FLAG 8'h80
`define TCI_EXC_MODE 8'h01
`define TCI_EXC_ARG 8'h02
`define TCI_EXC_LEN 8'h03
`define TCI_EXC_SAVE 8'h04
`define TCI_EXC_INIT 8'h20
`define TCI_LEN_SHORT 4'h5
`define TCI_LEN_POINT 4'h9
`define TCI_LEN_VALUE 4'h9
`define TCI_LEN_MIN 4'h4
`define TCI_MAX_CH_FLOAT 8'h05
`define TCI_MAX_CH_CONDUCT 8'h0b
`define TCI_MAX_CH_INT 8'h05
`define TCI_MAX_CFG_INDEX 8'h08
`define TCI_MAX_ZERO_CMD 8'h0d
`define TCI_CRC_INIT 16'hffff
`define TCI_CRC_POLY 16'ha001
`define TCI_FP_ZERO 32'h00000000
`define TCI_FP_EXP_ONES 8'hff
`define TCI_INT_POS_LIMIT 32'h7fffffff
`define TCI_INT_NEG_LIMIT 32'h80000000
`define TCI_VAR_BASIC 2'h0
`define TCI_VAR_CONDUCT 2'h1
`define TCI_VAR_DUAL 2'h2
`endif

// file: rtl/tci_pkg.sv
/*
  Types of the transmitter command interpreter: state enum and state struct.
  Assumes tci_map.svh is reachable on the include path.
*/
`include "tci_map.svh"
package tci_pkg;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_RX, ST_CHECK, ST_EXEC, ST_WAITZP, ST_CRC, ST_SEND} tci_state_e;
  typedef logic [`TCI_BUF_DEPTH-1:0][7:0] tci_buf_t;
  typedef struct packed {
    tci_state_e st;
    tci_buf_t buf_r;
    logic [3:0] cnt;
    logic [3:0] txi;
    logic ovf;
    logic [7:0] exc;
    logic [7:0] node_addr;
    logic dev_init;
    logic wait_r;
    logic [31:0] rdata;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic zp_wr;
    logic [3:0] zp_chan;
    logic [31:0] zp_ref;
    logic [31:0] zp_target;
    logic zp_reset;
  } tci_state_s;
endpackage

// file: dv/tci_properties.sv
/*
  Checker of the interpreter's bus, link and zero-point ports.
  Assumes it is bound to tci_interp on one clock.
*/
`timescale 1ns/100ps
module tci_properties (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Bus
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Link and status
  input wire logic i_rx_valid,
  input wire logic i_rx_last,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic o_tx_last,
  input wire logic i_tx_ready,
  input wire logic i_powerup_flag,
  input wire logic i_analog_calc_error_flag,
  input wire logic [5:0] i_chan_err,
  // Zero point
  input wire logic o_zp_wr,
  input wire logic [31:0] o_zp_target,
  input wire logic o_zp_reset
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // Steps of a request
  // ----------------------------------------
  sequence req_taken;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence frame_end;
    i_rx_valid && i_rx_last && !o_tx_valid;
  endsequence
  wait_answer_a: assert property (req_taken |=> !o_avs_waitrequest)
    else $error("waitrequest stayed high");
  wait_single_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low twice");
  wait_idle_a: assert property (!(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low without request");
  unmapped_zero_a: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address != 4'h0
    && i_avs_address != 4'h4 |-> o_avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  stat_byte_a: assert property ((req_taken ##0 (i_avs_read && i_avs_address == 4'h4)) |=>
    o_avs_readdata[23:16] == {$past(i_powerup_flag), $past(i_analog_calc_error_flag), $past(i_chan_err)})
    else $error("status byte wrong");
  reply_gap_a: assert property (frame_end |=> !o_tx_valid [*2])
    else $error("reply too early");
  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
    else $error("tx byte dropped");
  tx_stop_a: assert property (o_tx_valid && o_tx_last && i_tx_ready |=> !o_tx_valid)
    else $error("tx after last byte");
  zp_pulse_a: assert property (o_zp_wr |=> !o_zp_wr)
    else $error("zero write longer than one cycle");
  reset_zero_a: assert property (o_zp_wr && o_zp_reset |-> o_zp_target == 32'h00000000)
    else $error("reset target not zero");
endmodule
bind tci_interp tci_properties i_tci_properties (.i_ref_clk, .i_reset, .i_avs_address, .i_avs_read,
  .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_rx_valid, .i_rx_last, .o_tx_valid, .o_tx_data,
  .o_tx_last, .i_tx_ready, .i_powerup_flag, .i_analog_calc_error_flag, .i_chan_err, .o_zp_wr,
  .o_zp_target, .o_zp_reset);

// file: dv/tci_host_model.sv
/*
  Host model: sends request frames with checksum and collects the reply.
  Assumes the interpreter's byte ports on the same clock.
*/
`timescale 1ns/100ps
module tci_host_model (
  // Clock and speed
  input wire logic i_ref_clk,
  input wire logic i_slow,
  // Request bytes
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_rx_last,
  // Reply bytes
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_last,
  output logic o_tx_ready
);
  logic [7:0] resp[$];
  logic got = 1'b0;
  logic ph = 1'b0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
    o_rx_last = 1'b0;
    o_tx_ready = 1'b0;
  end
  // Checksum over a byte list, reflected polynomial
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  // Frame out: body, checksum high then low, last flag on final byte
  task automatic send(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc(q);
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
    resp.delete();
    got = 1'b0;
    foreach (q[i]) begin
      @(posedge i_ref_clk);
      o_rx_valid <= 1'b1;
      o_rx_data <= q[i];
      o_rx_last <= (i == q.size() - 1);
    end
    @(posedge i_ref_clk);
    o_rx_valid <= 1'b0;
    o_rx_last <= 1'b0;
    o_rx_data <= ~o_rx_data; // Released line shows no stale byte
  endtask
  // Reply in: ready every cycle, or every other cycle when slow
  always @(posedge i_ref_clk) begin
    ph <= ~ph;
    o_tx_ready <= !i_slow || ph;
    if (i_tx_valid && o_tx_ready) begin
      resp.push_back(i_tx_data);
      if (i_tx_last) got <= 1'b1;
    end
  end
endmodule

// file: dv/tb_transmitter_cmd_interpreter.sv
/*
  Self-checking bench of the command interpreter.
  Assumes tci_map.svh on the include path; design VARIANT left at dual.
*/
`timescale 1ns/100ps
`include "tci_map.svh"
module tb_transmitter_cmd_interpreter;
  logic i_ref_clk = 1'b0;
  logic i_reset, i_avs_read, i_avs_write, o_avs_waitrequest, i_rx_valid, i_rx_last, o_tx_valid, o_tx_last;
  logic i_tx_ready, i_powerup_flag, i_analog_calc_error_flag, o_zp_wr, o_zp_reset, i_zp_done, i_zp_fail, slow;
  logic [3:0] i_avs_address, o_zp_chan, zch_c;
  logic [31:0] i_avs_writedata, o_avs_readdata, o_zp_ref, o_zp_target, q, zref_c, ztgt_c;
  logic [7:0] i_rx_data, o_tx_data, na;
  logic [5:0] i_chan_err;
  logic [11:0][31:0] i_chan_float;
  logic [5:0][31:0] i_chan_int;
  logic [8:0][39:0] i_config_param_byte;
  logic zrst_c;
  int fail_count = 0;
  int num_checks = 0;
  tci_interp i_tci_interp (.i_ref_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .o_avs_readdata, .o_avs_waitrequest, .i_rx_valid, .i_rx_data, .i_rx_last, .o_tx_valid, .o_tx_data,
    .o_tx_last, .i_tx_ready, .i_chan_float, .i_chan_int, .i_powerup_flag, .i_analog_calc_error_flag,
    .i_chan_err, .i_config_param_byte, .o_zp_wr, .o_zp_chan, .o_zp_ref, .o_zp_target, .o_zp_reset,
    .i_zp_done, .i_zp_fail);
  tci_host_model i_tci_host_model (.i_ref_clk, .i_slow(slow), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data),
    .o_rx_last(i_rx_last), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .i_tx_last(o_tx_last),
    .o_tx_ready(i_tx_ready));
  // Clock
  always #25 i_ref_clk = ~i_ref_clk;
  // Calibration engine: acknowledge each zero-point write, keep its fields
  always @(posedge i_ref_clk) begin
    i_zp_done <= o_zp_wr;
    if (o_zp_wr) begin
      zch_c <= o_zp_chan;
      zref_c <= o_zp_ref;
      ztgt_c <= o_zp_target;
      zrst_c <= o_zp_reset;
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic timeout();
    fail_count++;
    test_done();
  endtask
  // Bus access held until waitrequest is sampled low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge i_ref_clk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) timeout();
    r = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  // One request frame and its expected reply
  task automatic xact(input logic [7:0] rq[$], input logic [7:0] ex[$]);
    logic [15:0] c;
    int n;
    c = i_tci_host_model.crc(ex);
    ex.push_back(c[15:8]);
    ex.push_back(c[7:0]);
    i_tci_host_model.send(rq);
    for (n = 0; n < 400 && i_tci_host_model.got !== 1'b1; n++) @(posedge i_ref_clk);
    if (n >= 400) timeout();
    check(32'(i_tci_host_model.resp.size()), 32'(ex.size()));
    foreach (ex[i]) check({24'h0, i_tci_host_model.resp[i]}, {24'h0, ex[i]});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_uninit();
    xact({na, `TCI_FN_READ_FLOAT, 8'h01}, {na, 8'hc9, 8'h20});
    $display("uninit done");
  endtask
  task automatic t_regs();
    av(1'b0, 4'h0, 32'h0, q);
    check(q, 32'h00000100);
    av(1'b1, 4'h0, 32'h00002101, q);
    na = 8'h21;
    av(1'b0, 4'h0, 32'h0, q);
    check(q, 32'h00002101);
    av(1'b0, 4'h4, 32'h0, q);
    check(q, 32'h00450020);
    av(1'b0, 4'h8, 32'h0, q);
    check(q, 32'h0);
    $display("regs done");
  endtask
  task automatic t_reset();
    @(posedge i_ref_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    na = 8'h01;
    av(1'b0, 4'h0, 32'h0, q);
    check(q, 32'h00000100);
    av(1'b0, 4'h4, 32'h0, q);
    check(q, 32'h00450000);
    xact({na, `TCI_FN_READ_CFG, 8'h00}, {na, 8'he4, 8'h20});
    $display("reset done");
  endtask
  task automatic t_read();
    slow <= 1'b1;
    xact({na, `TCI_FN_READ_INT, 8'h01}, {na, 8'h4a, 8'h12, 8'h34, 8'h56, 8'h78, 8'h45});
    xact({na, `TCI_FN_READ_INT, 8'h02}, {na, 8'h4a, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h45});
    xact({na, `TCI_FN_READ_INT, 8'h03}, {na, 8'h4a, 8'h80, 8'h00, 8'h00, 8'h00, 8'h45});
    xact({na, `TCI_FN_READ_INT, 8'h0a}, {na, 8'hca, 8'h02});
    xact({8'hfa, `TCI_FN_READ_FLOAT, 8'h01}, {8'hfa, 8'h49, 8'h41, 8'h29, 8'h02, 8'hde, 8'h45});
    slow <= 1'b0;
    $display("read done");
  endtask
  task automatic t_zero();
    logic [7:0] rc[10] = '{8'h01, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [3:0] rch[10] = '{4'h1, 4'h2, 4'h0, 4'h0, 4'h3, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5};
    xact({na, `TCI_FN_ZERO, 8'h00}, {na, 8'h5f, 8'h00});
    check({27'h0, zrst_c, zch_c}, 32'h1);
    check(zref_c, i_chan_float[1]);
    check(ztgt_c, 32'h0);
    xact({na, `TCI_FN_ZERO, 8'h02, 8'h3f, 8'h80, 8'h00, 8'h00}, {na, 8'h5f, 8'h00});
    check({27'h0, zrst_c, zch_c}, 32'h2);
    check(ztgt_c, 32'h3f800000);
    for (int k = 0; k < 10; k++) begin
      xact({na, `TCI_FN_ZERO, rc[k]}, {na, 8'h5f, 8'h00});
      check({27'h0, zrst_c, zch_c}, {27'h0, rc[k][0], rch[k]});
      check(ztgt_c, 32'h0);
    end
    $display("zero done");
  endtask
  task automatic t_refuse();
    xact({na, `TCI_FN_ZERO, 8'h04}, {na, 8'hdf, 8'h02});
    xact({na, `TCI_FN_ZERO, 8'h00, 8'h00}, {na, 8'hdf, 8'h03});
    i_powerup_flag <= 1'b1;
    xact({na, `TCI_FN_ZERO, 8'h00}, {na, 8'hdf, 8'h01});
    i_powerup_flag <= 1'b0;
    xact({na, `TCI_FN_READ_CFG, 8'h08}, {na, 8'h64, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05});
    xact({na, `TCI_FN_READ_CFG, 8'h09}, {na, 8'he4, 8'h02});
    xact({na, `TCI_FN_READ_CFG, 8'h08, 8'h00}, {na, 8'he4, 8'h03});
    $display("refuse done");
  endtask
  // Main sequence
  initial begin
    i_reset = 1'b1;
    {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = '0;
    {i_powerup_flag, i_zp_fail, slow, i_zp_done} = '0;
    i_analog_calc_error_flag = 1'b1;
    i_chan_err = 6'h05;
    i_chan_float = '0;
    i_chan_float[1] = 32'h412902de;
    i_chan_float[2] = 32'h7f800000;
    i_chan_float[3] = 32'hff800000;
    i_chan_int = '0;
    i_chan_int[1] = 32'h12345678;
    i_config_param_byte = '0;
    i_config_param_byte[8] = 40'h0504030201;
    na = 8'h01;
    repeat (16) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    t_uninit();
    t_regs();
    t_read();
    t_zero();
    t_refuse();
    t_reset();
    test_done();
  end
endmodule
